// File: fbw_interp.v
// Purpose: interpret the cyclic fieldbus write words of a drive
// Assumes: exchange words come from board logic on core_clk_i
// Notes: parameter table and drive core sit outside this block
`timescale 1ns/100ps
`default_nettype none
`include "fbw_consts.vh"

module fbw_interp #(
	parameter CTRL_TYPE_NUM = 16'd202
) (
	input  wire        core_clk_i,
	input  wire        rst_n_i,
	input  wire        exch_strobe_i,
	input  wire [15:0] wr_ctrl_i,
	input  wire [15:0] wr_speed_i,
	input  wire [15:0] wr_outs_i,
	input  wire [15:0] wr_rd_num_i,
	input  wire [15:0] wr_chg_num_i,
	input  wire [15:0] wr_chg_val_i,
	input  wire [3:0]  bus_protocol_select_i,
	input  wire [2:0]  link_loss_action_i,
	input  wire [4:0]  output_source_config_i,
	input  wire [4:0]  func_assign_i,
	input  wire [15:0] sync_rpm_i,
	input  wire [15:0] max_rpm_i,
	input  wire        drive_enabled_i,
	input  wire        motor_model_zero_i,
	input  wire [7:0]  drive_status_i,
	input  wire        link_up_i,
	input  wire        board_present_i,
	input  wire        board_ok_i,
	input  wire [1:0]  board_protocol_i,
	input  wire        program_key_i,
	input  wire [15:0] param_rd_data_i,
	input  wire        param_rd_exists_i,
	input  wire        par_exists_i,
	input  wire        par_read_only_i,
	input  wire        par_stop_only_i,
	input  wire        par_conflict_i,
	input  wire [15:0] par_min_i,
	input  wire [15:0] par_max_i,
	output reg  [4:0]  cmd_o,
	output reg         fault_reset_o,
	output reg         save_enable_o,
	output reg  [15:0] speed_rpm_o,
	output wire        transistor_output_a_o,
	output wire        transistor_output_b_o,
	output wire        relay_output_a_o,
	output wire        relay_output_b_o,
	output wire        relay_output_c_o,
	output reg  [15:0] param_rd_num_o,
	output reg  [15:0] rd_content_o,
	output reg  [15:0] par_wr_num_o,
	output reg  [15:0] par_wr_val_o,
	output reg         par_wr_o,
	output wire [15:0] status_word_o,
	output wire        param_locked_fault_o,
	output wire        missing_param_fault_o,
	output wire        value_range_fault_o,
	output wire        not_assigned_fault_o,
	output reg         link_inactive_fault_o,
	output reg         board_inactive_fault_o,
	output wire        ramp_stop_o,
	output wire        coast_stop_o,
	output wire        go_local_o,
	output wire        keep_cmd_ref_o
);

// =============================================
// functions

// words used per protocol setting, zero when inactive
function [2:0] words_used;
	input [3:0] sel;
	begin
		case (sel)
			4'd1, 4'd4, 4'd7: words_used = 3'd2;
			4'd2, 4'd5:       words_used = 3'd4;
			4'd3, 4'd6:       words_used = 3'd6;
			default:          words_used = 3'd0;
		endcase
	end
endfunction

// protocol family that the fitted board must match
function [1:0] family;
	input [3:0] sel;
	begin
		case (sel)
			4'd1, 4'd2, 4'd3: family = 2'd1;
			4'd4, 4'd5, 4'd6: family = 2'd2;
			4'd7:             family = 2'd3;
			default:          family = 2'd0;
		endcase
	end
endfunction

// ref*sync/8191 as (p + p/8192 + 1)/8192, exact at 8191
function [15:0] scale;
	input [15:0] r;
	input [15:0] s;
	input [15:0] m;
	reg   [31:0] p;
	reg   [31:0] q;
	begin
		p = r * s;
		q = (p + (p >> 13) + 32'd1) >> 13;
		if (q > {16'h0000, m})
			scale = m;
		else
			scale = q[15:0];
	end
endfunction

// =============================================
// exchange decode
reg  [15:0] prev_ctrl_r;
reg  [15:0] last_num_r;
reg  [15:0] last_val_r;
reg  [4:0]  outs_r;
reg         rd_pend_r;
reg         wr_pend_r;
reg         lock_r;
reg         miss_rd_r;
reg         miss_wr_r;
reg         range_r;
reg         ro_r;
reg         fn_bad_r;
reg         out_bad_r;
reg         link_m_r;
reg         link_s_r;
reg         key_m_r;
reg         key_s_r;
reg         key_d_r;

wire [2:0] cnt     = words_used(bus_protocol_select_i);
wire       do_exch = exch_strobe_i & (cnt != 3'd0);
wire       has4    = do_exch & (cnt >= 3'd4);
wire       has6    = do_exch & (cnt == 3'd6);
// words are indexed from zero in the board memory
wire       idle    = has6 & (wr_chg_num_i == `FBW_IDLE_NUM);
wire       chg_req = has6 & ~idle &
	((wr_chg_num_i != last_num_r) | (wr_chg_val_i != last_val_r));
wire       cw_chg  = do_exch & (wr_ctrl_i != prev_ctrl_r);
wire [4:0] fn_sel  = wr_ctrl_i[`FBW_MASK_LSB+4:`FBW_MASK_LSB];
wire [4:0] out_sel = wr_outs_i[`FBW_MASK_LSB+4:`FBW_MASK_LSB];
wire       fn_set  = do_exch & |(fn_sel & ~func_assign_i);
wire       out_set = has4 & |(out_sel & ~output_source_config_i);

// =============================================
// write evaluation, one cycle after the request is latched
wire prot    = (par_wr_num_o == `FBW_NUM_TUNE) |
	(par_wr_num_o == `FBW_NUM_FACT);
wire to_vec  = (par_wr_num_o == CTRL_TYPE_NUM) &
	(par_wr_val_o >= `FBW_VEC_MIN) & motor_model_zero_i;
wire e_miss  = wr_pend_r & (~par_exists_i | prot);
wire e_ro    = wr_pend_r & ~e_miss & par_read_only_i;
wire e_lock  = wr_pend_r & ~e_miss & ~e_ro &
	((par_stop_only_i & drive_enabled_i) | par_conflict_i |
	to_vec);
wire e_range = wr_pend_r & ~e_miss & ~e_ro & ~e_lock &
	((par_wr_val_o < par_min_i) | (par_wr_val_o > par_max_i));
wire wr_ok   = wr_pend_r & ~e_miss & ~e_ro & ~e_lock & ~e_range;
wire clr_wr  = wr_ok | idle;

// =============================================
// control word, speed and outputs
// a set in the same cycle as a clear wins
always @(posedge core_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		prev_ctrl_r   <= `FBW_RST_WORD;
		cmd_o         <= `FBW_RST_BITS5;
		fault_reset_o <= 1'b0;
		save_enable_o <= 1'b1;
		speed_rpm_o   <= `FBW_RST_WORD;
		outs_r        <= `FBW_RST_BITS5;
		fn_bad_r      <= 1'b0;
		out_bad_r     <= 1'b0;
	end else begin
		fault_reset_o <= 1'b0;
		if (do_exch) begin
			prev_ctrl_r <= wr_ctrl_i;
			// only masked and bus-assigned functions move
			cmd_o <= (cmd_o & ~(fn_sel & func_assign_i)) |
				(wr_ctrl_i[4:0] & fn_sel & func_assign_i);
			fault_reset_o <= wr_ctrl_i[`FBW_CW_RST] &
				wr_ctrl_i[`FBW_CW_RSTV] &
				~prev_ctrl_r[`FBW_CW_RSTV];
			if (wr_ctrl_i[`FBW_CW_SAVE])
				save_enable_o <= ~wr_ctrl_i[`FBW_CW_SAVEV];
			speed_rpm_o <= scale(wr_speed_i, sync_rpm_i,
				max_rpm_i);
		end
		if (has4) begin
			// masked bus-sourced outputs take the state bit, others hold
			outs_r <= (outs_r & ~(out_sel & output_source_config_i)) |
				(wr_outs_i[4:0] & out_sel &
				output_source_config_i);
		end
		// control- and output-mask faults clear only on a new control word
		fn_bad_r  <= fn_set | (fn_bad_r & ~cw_chg);
		out_bad_r <= out_set | (out_bad_r & ~cw_chg);
	end
end

assign transistor_output_a_o = outs_r[0];
assign transistor_output_b_o = outs_r[1];
assign relay_output_a_o      = outs_r[2];
assign relay_output_b_o      = outs_r[3];
assign relay_output_c_o      = outs_r[4];

// =============================================
// parameter read and change
// values pass as plain integers, no scaling here
always @(posedge core_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		param_rd_num_o <= `FBW_RST_WORD;
		rd_content_o   <= `FBW_RST_WORD;
		rd_pend_r      <= 1'b0;
		miss_rd_r      <= 1'b0;
		par_wr_num_o   <= `FBW_IDLE_NUM;
		par_wr_val_o   <= `FBW_RST_WORD;
		last_num_r     <= `FBW_IDLE_NUM;
		last_val_r     <= `FBW_RST_WORD;
		wr_pend_r      <= 1'b0;
		par_wr_o       <= 1'b0;
		lock_r         <= 1'b0;
		miss_wr_r      <= 1'b0;
		range_r        <= 1'b0;
		ro_r           <= 1'b0;
	end else begin
		rd_pend_r <= has4;
		if (has4)
			param_rd_num_o <= wr_rd_num_i;
		if (rd_pend_r) begin
			if (param_rd_exists_i)
				rd_content_o <= param_rd_data_i;
			miss_rd_r <= ~param_rd_exists_i;
		end
		wr_pend_r <= chg_req;
		if (chg_req) begin
			// one attempt per new number/value pair
			par_wr_num_o <= wr_chg_num_i;
			par_wr_val_o <= wr_chg_val_i;
			last_num_r   <= wr_chg_num_i;
			last_val_r   <= wr_chg_val_i;
		end else if (idle) begin
			last_num_r <= `FBW_IDLE_NUM;
		end
		// rejected values never reach the parameter table
		par_wr_o  <= wr_ok;
		lock_r    <= e_lock | (lock_r & ~clr_wr);
		miss_wr_r <= e_miss | (miss_wr_r & ~clr_wr);
		range_r   <= e_range | (range_r & ~clr_wr);
		ro_r      <= e_ro | (ro_r & ~clr_wr);
	end
end

// =============================================
// fault indications in the status word
// these flags feed no command path, so drive state is unchanged
assign param_locked_fault_o  = lock_r;
assign missing_param_fault_o = miss_rd_r | miss_wr_r;
assign value_range_fault_o   = range_r;
assign not_assigned_fault_o  = ro_r | fn_bad_r | out_bad_r;

reg [7:0] code_w;
always @* begin
	if (param_locked_fault_o)
		code_w = `FBW_CODE_LOCK;
	else if (missing_param_fault_o)
		code_w = `FBW_CODE_MISS;
	else if (value_range_fault_o)
		code_w = `FBW_CODE_RANGE;
	else if (not_assigned_fault_o)
		code_w = `FBW_CODE_NASG;
	else
		code_w = `FBW_CODE_NONE;
end

assign status_word_o = {drive_status_i, code_w};

// =============================================
// link and board supervision
// link and key are pins, so both pass two flops first
always @(posedge core_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		// reset to the connected level, else a false loss follows reset
		link_m_r <= 1'b1;
		link_s_r <= 1'b1;
		key_m_r  <= 1'b0;
		key_s_r  <= 1'b0;
		key_d_r  <= 1'b0;
	end else begin
		link_m_r <= link_up_i;
		link_s_r <= link_m_r;
		key_m_r  <= program_key_i;
		key_s_r  <= key_m_r;
		key_d_r  <= key_s_r;
	end
end

wire bus_on  = (bus_protocol_select_i != 4'd0);
wire key_hit = key_s_r & ~key_d_r;
wire lnk_set = bus_on & board_present_i & board_ok_i & ~link_s_r;
wire brd_set = bus_on & (~board_present_i | ~board_ok_i |
	(board_protocol_i != family(bus_protocol_select_i)));

// a persisting cause sets again over the key clear
always @(posedge core_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		link_inactive_fault_o  <= 1'b0;
		board_inactive_fault_o <= 1'b0;
	end else begin
		link_inactive_fault_o  <= lnk_set |
			(link_inactive_fault_o & ~key_hit);
		board_inactive_fault_o <= brd_set |
			(board_inactive_fault_o & ~key_hit);
	end
end

// =============================================
// action while either supervision fault is shown
wire loss = link_inactive_fault_o | board_inactive_fault_o;

assign ramp_stop_o    = loss &
	(link_loss_action_i == `FBW_ACT_RAMP);
assign coast_stop_o   = loss &
	(link_loss_action_i == `FBW_ACT_COAST);
assign go_local_o     = loss &
	((link_loss_action_i == `FBW_ACT_LOCAL) |
	(link_loss_action_i == `FBW_ACT_LKEEP));
assign keep_cmd_ref_o = loss &
	(link_loss_action_i == `FBW_ACT_LKEEP);

endmodule // fbw_interp
`default_nettype wire

// File: fbw_consts.vh
// Purpose: shared constants of the fieldbus write-word interpreter
// Assumes: 16-bit exchanged words, core clock of 200 MHz
// Notes: included by fbw_interp.v
`ifndef FBW_CONSTS_VH
`define FBW_CONSTS_VH

// =============================================
// word values
`define FBW_IDLE_NUM   16'h03E7
`define FBW_SYNC_REF   32'h00001FFF
`define FBW_NUM_TUNE   16'h0198
`define FBW_NUM_FACT   16'h00CC
`define FBW_VEC_MIN    16'h0003

// =============================================
// field positions
`define FBW_MASK_LSB   8
`define FBW_CW_RST     15
`define FBW_CW_RSTV    7
`define FBW_CW_SAVE    13
`define FBW_CW_SAVEV   5

// =============================================
// fault codes shown in the low byte of the status word
`define FBW_CODE_NONE  8'h00
`define FBW_CODE_LOCK  8'h18
`define FBW_CODE_MISS  8'h19
`define FBW_CODE_RANGE 8'h1A
`define FBW_CODE_NASG  8'h1B

// =============================================
// link-loss actions
`define FBW_ACT_RAMP   3'h0
`define FBW_ACT_COAST  3'h1
`define FBW_ACT_KEEP   3'h2
`define FBW_ACT_LOCAL  3'h3
`define FBW_ACT_LKEEP  3'h4

// =============================================
// reset values
`define FBW_RST_WORD   16'h0000
`define FBW_RST_BITS5  5'h00

`endif

// File: fbw_asserts.sv
// Purpose: port checks of the fieldbus write-word interpreter
// Assumes: one clock domain, asynchronous active-low reset
// Notes: sees only the ports of fbw_interp
`timescale 1ns/100ps
`default_nettype none
`include "fbw_consts.vh"
module fbw_asserts (
	input wire        core_clk_i, rst_n_i, exch_strobe_i,
	input wire [15:0] wr_ctrl_i, wr_outs_i, wr_chg_num_i,
	input wire [3:0]  bus_protocol_select_i,
	input wire [2:0]  link_loss_action_i,
	input wire [4:0]  output_source_config_i, cmd_o,
	input wire [15:0] max_rpm_i, par_min_i, par_max_i,
	input wire [15:0] speed_rpm_o, par_wr_val_o, status_word_o,
	input wire        par_exists_i, par_read_only_i, par_wr_o,
	input wire        transistor_output_a_o, param_locked_fault_o,
	input wire        link_inactive_fault_o, board_inactive_fault_o,
	input wire        ramp_stop_o, coast_stop_o, go_local_o, keep_cmd_ref_o
);
	// =========================================
	// checks, all on the core clock
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_idle_no_write: assert property (par_wr_o |->
		$past(exch_strobe_i, 2) && $past(wr_chg_num_i, 2) != `FBW_IDLE_NUM)
		else $error("write applied without a change request");
	a_write_legal: assert property (par_wr_o |-> par_exists_i &&
		!par_read_only_i && par_wr_val_o >= par_min_i &&
		par_wr_val_o <= par_max_i) else $error("illegal write applied");
	a_locked_code: assert property (param_locked_fault_o |->
		status_word_o[7:0] == `FBW_CODE_LOCK) else $error("locked code");
	a_faults_no_stop: assert property (!link_inactive_fault_o &&
		!board_inactive_fault_o |-> !(ramp_stop_o || coast_stop_o ||
		go_local_o || keep_cmd_ref_o)) else $error("state changed");
	a_out_masked: assert property (exch_strobe_i &&
		(!wr_outs_i[8] || !output_source_config_i[0]) |=>
		$stable(transistor_output_a_o)) else $error("unmasked output");
	a_out_state: assert property (exch_strobe_i && wr_outs_i[8] &&
		output_source_config_i[0] && bus_protocol_select_i inside {2, 3, 5, 6}
		|=> transistor_output_a_o == $past(wr_outs_i[0]))
		else $error("output state wrong");
	a_cmd_masked: assert property (exch_strobe_i && !wr_ctrl_i[8] |=>
		$stable(cmd_o[0])) else $error("command bit without mask");
	a_speed_clamp: assert property (speed_rpm_o <= max_rpm_i)
		else $error("speed above maximum");
	a_ramp_loss: assert property (link_inactive_fault_o &&
		link_loss_action_i == `FBW_ACT_RAMP |-> ramp_stop_o)
		else $error("no ramp stop on link loss");
	c_write: cover property (par_wr_o);
	c_locked: cover property (param_locked_fault_o);
	c_link: cover property (link_inactive_fault_o);
endmodule // fbw_asserts
bind fbw_interp fbw_asserts i_fbw_asserts (.*);
`default_nettype wire

// File: fbw_mst.sv
// Purpose: model of the fieldbus master writing the six words
// Assumes: words change just after a clock edge
// Notes: change number starts at idle; later words stand until the next request
`timescale 1ns/100ps
`default_nettype none
`include "fbw_consts.vh"
module fbw_mst (
	input  wire        clk_i,
	output reg         stb_o,
	output reg  [95:0] wd_o
);
	// =========================================
	// idle words until the first exchange
	initial begin
		stb_o = 1'b0;
		wd_o = {64'h0, `FBW_IDLE_NUM, 16'h0};
	end
	// one exchange; words stand until the next call, so the content
	// is held while the interpreter works on it
	task xfer(input [95:0] w);
		begin
			@(posedge clk_i) #1;
			wd_o = w;
			stb_o = 1'b1;
			@(posedge clk_i) #1;
			stb_o = 1'b0;
			repeat (3) @(posedge clk_i);
			#1;
		end
	endtask
endmodule // fbw_mst
`default_nettype wire

// File: testbench.sv
// Purpose: self-checking bench of the write-word interpreter
// Assumes: six-word protocol setting, 200 MHz core clock
// Notes: parameter table is modelled by the assigns below
`timescale 1ns/100ps
`default_nettype none
`include "fbw_consts.vh"
module testbench;
	localparam [15:0] I9 = `FBW_IDLE_NUM;
	reg         core_clk_i, rst_n_i, drive_enabled_i, motor_model_zero_i;
	reg         link_up_i, board_present_i, program_key_i, seen;
	reg  [4:0]  output_source_config_i;
	reg  [2:0]  link_loss_action_i;
	reg  [3:0]  bus_protocol_select_i;
	reg  [15:0] sync_rpm_i, max_rpm_i, e;
	integer     error_cnt, checked, i, r;
	wire        exch_strobe_i, fault_reset_o, save_enable_o, par_wr_o;
	wire [95:0] w;
	wire [15:0] wr_ctrl_i, wr_speed_i, wr_outs_i, wr_rd_num_i, wr_chg_num_i;
	wire [15:0] wr_chg_val_i, speed_rpm_o, param_rd_num_o, rd_content_o;
	wire [15:0] par_wr_num_o, par_wr_val_o, status_word_o;
	wire [4:0]  cmd_o;
	wire        transistor_output_a_o, transistor_output_b_o;
	wire        relay_output_a_o, relay_output_b_o, relay_output_c_o;
	wire        param_locked_fault_o, missing_param_fault_o;
	wire        value_range_fault_o, not_assigned_fault_o;
	wire        link_inactive_fault_o, board_inactive_fault_o;
	wire        ramp_stop_o, coast_stop_o, go_local_o, keep_cmd_ref_o;
	wire [4:0]  outs = {relay_output_c_o, relay_output_b_o,
		relay_output_a_o, transistor_output_b_o, transistor_output_a_o};
	wire [3:0]  loss = {keep_cmd_ref_o, go_local_o, coast_stop_o, ramp_stop_o};
	// =========================================
	// fixed drive side; table: below 500 exists, 2 read-only, 100 locked
	wire [4:0]  func_assign_i = 5'h1F;
	wire [7:0]  drive_status_i = 8'h5A;
	wire [1:0]  board_protocol_i = 2'h1;
	wire        board_ok_i = board_present_i;
	wire [15:0] param_rd_data_i = param_rd_num_o ^ 16'hA5A5;
	wire        param_rd_exists_i = param_rd_num_o < 16'd500;
	wire        par_exists_i = par_wr_num_o < 16'd500;
	wire        par_read_only_i = par_wr_num_o == 16'd2;
	wire        par_stop_only_i = par_wr_num_o == 16'd100;
	wire        par_conflict_i = 1'b0;
	wire [15:0] par_min_i = 16'd0;
	wire [15:0] par_max_i = par_wr_num_o + 16'd50;
	assign {wr_ctrl_i, wr_speed_i, wr_outs_i, wr_rd_num_i, wr_chg_num_i,
		wr_chg_val_i} = w;
	fbw_interp i_dut (.*);
	fbw_mst i_mst (.clk_i(core_clk_i), .stb_o(exch_strobe_i), .wd_o(w));
	// apply pulse lasts one cycle, so it is caught here
	always @(posedge core_clk_i)
		if (par_wr_o === 1'b1 || fault_reset_o === 1'b1) seen <= 1'b1;
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	// =========================================
	// helpers
	task chk(input [31:0] g, input [31:0] x);
		begin
			checked = checked + 1;
			if (g !== x) begin
				error_cnt = error_cnt + 1;
				$display("ERROR %0t got %h exp %h", $time, g, x);
			end
		end
	endtask
	task cy(input integer n);
		begin
			repeat (n) @(posedge core_clk_i);
			#1;
		end
	endtask
	task x(input [15:0] c, s, o, d, n, v);
		begin
			seen = 1'b0;
			i_mst.xfer({c, s, o, d, n, v});
		end
	endtask
	// idle first, then the change; idle must leave the code clear
	task wr(input [15:0] n, v, input [7:0] k, input p);
		begin
			x(16'h0101, 0, 0, 16'd100, I9, 0);
			chk(status_word_o, {8'h5A, `FBW_CODE_NONE});
			x(16'h0101, 0, 0, 16'd100, n, v);
			chk(status_word_o, {8'h5A, k});
			chk(seen, p);
		end
	endtask
	task kp;
		begin
			program_key_i = 1'b1;
			cy(4);
			program_key_i = 1'b0;
			cy(6);
		end
	endtask
	task give_verdict;
		begin
			if (error_cnt == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		#20000;
		error_cnt = error_cnt + 1;
		give_verdict;
	end
	// =========================================
	// main sequence
	initial begin
		{error_cnt, checked, seen, rst_n_i, program_key_i} = 0;
		{drive_enabled_i, motor_model_zero_i, link_loss_action_i} = 0;
		{link_up_i, board_present_i, output_source_config_i} = 7'h7F;
		bus_protocol_select_i = 4'h3;
		sync_rpm_i = 16'd1800;
		max_rpm_i = 16'd2000;
		cy(10);
		rst_n_i = 1'b1;
		chk(par_wr_num_o, I9);
		for (i = 0; i < 3; i = i + 1) begin
			e = (i == 0) ? 16'h0B8E : (i == 1) ? 16'h1FFF : 16'h3FFE;
			x(0, e, 0, 0, I9, 0);
			r = e * sync_rpm_i / 8191;
			chk(speed_rpm_o, r > max_rpm_i ? max_rpm_i : r);
		end
		chk({link_inactive_fault_o, board_inactive_fault_o, loss}, 0);
		x(0, 0, 16'h1F05, 0, I9, 0);
		chk(outs, 5'h05);
		x(0, 0, 16'h0102, 0, I9, 0);
		chk(outs, 5'h04);
		bus_protocol_select_i = 4'h1;
		x(0, 0, 16'h1F1F, 0, I9, 0);
		chk(outs, 5'h04);
		bus_protocol_select_i = 4'h3;
		output_source_config_i = 5'h1E;
		x(0, 0, 16'h0101, 0, I9, 0);
		chk({not_assigned_fault_o, outs}, 6'h24);
		x(0, 0, 0, 0, I9, 0);
		chk(status_word_o, {8'h5A, `FBW_CODE_NASG});
		x(16'h0001, 0, 0, 0, I9, 0);
		chk({not_assigned_fault_o, cmd_o}, 6'h00);
		x(16'h0101, 0, 0, 16'd100, I9, 0);
		chk({cmd_o[0], rd_content_o ^ 16'hA5A5}, 17'h10064);
		x(16'h0101, 0, 0, 16'd600, I9, 0);
		chk({missing_param_fault_o, status_word_o}, 17'h15A19);
		x(16'hA0A0, 0, 0, 16'd100, I9, 0);
		chk({seen, save_enable_o}, 2'b10);
		{drive_enabled_i, motor_model_zero_i} = 2'b11;
		wr(16'd150, 16'd50, `FBW_CODE_NONE, 1);
		wr(16'd150, 16'd250, `FBW_CODE_RANGE, 0);
		wr(16'd2, 16'd5, `FBW_CODE_NASG, 0);
		wr(16'd100, 16'd5, `FBW_CODE_LOCK, 0);
		wr(`FBW_NUM_TUNE, 16'd1, `FBW_CODE_MISS, 0);
		wr(16'd202, `FBW_VEC_MIN, `FBW_CODE_LOCK, 0);
		link_up_i = 1'b0;
		for (i = 0; i < 5; i = i + 1) begin
			link_loss_action_i = i;
			cy(4);
			e = (i == 4) ? 16'hC : (i == 3) ? 16'h4 : (i == 2) ? 0 : i + 1;
			chk({link_inactive_fault_o, loss}, e | 16'h10);
		end
		kp;
		chk(link_inactive_fault_o, 1);
		link_up_i = 1'b1;
		cy(4);
		kp;
		chk(link_inactive_fault_o, 0);
		board_present_i = 1'b0;
		cy(4);
		chk(board_inactive_fault_o, 1);
		board_present_i = 1'b1;
		kp;
		chk(board_inactive_fault_o, 0);
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
